// ---- lcdcmd_core.sv ----
// Purpose: multibyte command interpreter and power save control of an lcd driver
// Assumes: cmd_valid is a one-cycle strobe in the clk domain; pins pass synchronisers
// Notes:   display memory is an internal array filled by the burst engine
`timescale 1ns/1ps
module lcdcmd_core #(
    parameter int DEPTH = 1056,
    parameter int AW    = 11
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          cmd_valid,
    input  wire logic          command_data_select,
    input  wire logic [7:0]    cmd_byte,
    input  wire logic          timing_master,
    input  wire logic          host_ram_wr,
    input  wire logic [AW-1:0] host_ram_addr,
    input  wire logic [7:0]    host_ram_wdata,
    input  wire logic          host_ram_rd,
    output logic [7:0]         host_ram_rdata,
    output logic [7:0]         status_byte,
    output logic [5:0]         contrast_level,
    output logic [5:0]         dbl_start_line,
    output logic [5:0]         dbl_stop_line,
    output logic               dbl_size_on,
    output logic               frame_invert_enable,
    output logic [1:0]         alt_period_sel,
    output logic               frame_polarity,
    output logic               display_line_pulse,
    output logic               test_mode,
    output logic               power_save,
    output logic               sleep_mode,
    output logic               osc_enable,
    output logic               supply_enable,
    output logic               drive_enable,
    output logic               blanking_out_n
);
    if ((1 << AW) < DEPTH)
    begin
        $error("address width too small for depth");
    end

    // ==========================================
    // state
    lcdcmd_pkg::lcdcmd_arg_t arg_q, arg_d;
    logic [5:0]    contrast_q;
    logic [5:0]    start_q;
    logic [5:0]    stop_q;
    logic          dbl_on_q;
    logic          frs_q;
    logic [1:0]    alt_q;
    logic          test_q;
    logic          disp_on_q;
    logic          entire_q;
    logic          save_q;
    logic          sleep_q;
    logic [7:0]    div_q;
    logic          tick_q;
    logic [5:0]    fcnt_q;
    logic          fpol_q;
    logic          fill_start_q;
    logic [7:0]    fill_data_q;
    logic          burst_wait_q;
    logic [7:0]    rdata_q;
    logic [7:0]    status_q;
    logic          reset_flag_q;
    logic [7:0]    ram [DEPTH];

    lcdcmd_fill_if #(.AW(AW)) fif ();

    lcdcmd_fill #(.DEPTH(DEPTH), .AW(AW)) u_fill (
        .clk       (clk),
        .rst_n     (rst_n),
        .line_tick (tick_q),
        .f         (fif.fill)
    );

    assign fif.start = fill_start_q;
    assign fif.data  = fill_data_q;

    // ==========================================
    // decode
    wire       cmd      = cmd_valid && !command_data_select;
    wire       busy     = fif.busy || fill_start_q;
    wire       accept   = cmd && !busy;
    wire       pending  = (arg_q != lcdcmd_pkg::LCDCMD_IDLE) || burst_wait_q;
    wire       plain    = accept && !pending;
    wire       is_rst   = plain && (cmd_byte == lcdcmd_pkg::CMD_RESET);
    wire       is_nop   = plain && (cmd_byte == lcdcmd_pkg::CMD_NOP);
    wire       is_test  = plain && (cmd_byte[7:4] == lcdcmd_pkg::TEST_PREFIX);
    wire       is_alt   = plain && (cmd_byte[7:4] == lcdcmd_pkg::ALT_PREFIX);
    wire       alt_frs  = cmd_byte[lcdcmd_pkg::ALT_FRS_BIT];
    wire       is_eon   = plain && (cmd_byte == lcdcmd_pkg::CMD_ENTIRE_ON);
    wire       is_eoff  = plain && (cmd_byte == lcdcmd_pkg::CMD_ENTIRE_OFF);
    wire       is_don   = plain && (cmd_byte == lcdcmd_pkg::CMD_DISP_ON);
    wire       is_doff  = plain && (cmd_byte == lcdcmd_pkg::CMD_DISP_OFF);
    wire       is_slon  = plain && (cmd_byte == lcdcmd_pkg::CMD_SLEEP_ON);
    wire       is_sloff = plain && (cmd_byte == lcdcmd_pkg::CMD_SLEEP_OFF);
    wire       is_burst = plain && (cmd_byte == lcdcmd_pkg::CMD_BURST);
    wire       is_dnorm = plain && (cmd_byte == lcdcmd_pkg::CMD_DBL_NORMAL);
    wire       arg_byte = accept && (arg_q != lcdcmd_pkg::LCDCMD_IDLE);
    wire       fill_arg = accept && burst_wait_q;
    wire [5:0] line_arg = cmd_byte[5:0];

    function automatic logic [5:0] period_lines(input logic [1:0] sel);
        period_lines = 6'(({4'h0, sel} + 6'h01) * 6'd16 - 6'd1);
    endfunction

    // ==========================================
    // argument sequencer
    always_comb
    begin
        arg_d = arg_q;
        case (arg_q)
            lcdcmd_pkg::LCDCMD_IDLE:
            begin
                if (plain && cmd_byte == lcdcmd_pkg::CMD_CONTRAST)
                    arg_d = lcdcmd_pkg::LCDCMD_VR;
                else if (plain && cmd_byte == lcdcmd_pkg::CMD_DBL_POS)
                    arg_d = lcdcmd_pkg::LCDCMD_DSTART;
            end
            lcdcmd_pkg::LCDCMD_VR:
                if (accept)
                    arg_d = lcdcmd_pkg::LCDCMD_IDLE;
            lcdcmd_pkg::LCDCMD_DSTART:
                if (accept)
                    arg_d = lcdcmd_pkg::LCDCMD_DSTOP;
            lcdcmd_pkg::LCDCMD_DSTOP:
                if (accept)
                    arg_d = lcdcmd_pkg::LCDCMD_IDLE;
            default:
                arg_d = lcdcmd_pkg::LCDCMD_IDLE;
        endcase
        if (is_rst)
            arg_d = lcdcmd_pkg::LCDCMD_IDLE;
    end

    // ==========================================
    // command registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arg_q        <= lcdcmd_pkg::LCDCMD_IDLE;
            contrast_q   <= lcdcmd_pkg::CONTRAST_RST;
            start_q      <= lcdcmd_pkg::LINE_RST;
            stop_q       <= lcdcmd_pkg::LINE_RST;
            dbl_on_q     <= 1'b0;
            frs_q        <= 1'b1;
            alt_q        <= lcdcmd_pkg::ALT_RST;
            test_q       <= 1'b0;
            burst_wait_q <= 1'b0;
            fill_start_q <= 1'b0;
            fill_data_q  <= 8'h00;
            reset_flag_q <= 1'b0;
        end
        else
        begin
            arg_q        <= arg_d;
            fill_start_q <= fill_arg;
            reset_flag_q <= is_rst;
            if (arg_byte && arg_q == lcdcmd_pkg::LCDCMD_VR)
                contrast_q <= cmd_byte[5:0];
            if (arg_byte && arg_q == lcdcmd_pkg::LCDCMD_DSTART)
                start_q <= line_arg;
            if (arg_byte && arg_q == lcdcmd_pkg::LCDCMD_DSTOP)
            begin
                stop_q   <= line_arg;
                dbl_on_q <= 1'b1;
            end
            if (is_dnorm)
                dbl_on_q <= 1'b0;
            if (is_alt)
            begin
                frs_q <= alt_frs;
                alt_q <= cmd_byte[1:0];
            end
            if (is_burst)
                burst_wait_q <= 1'b1;
            else if (fill_arg || is_rst)
                burst_wait_q <= 1'b0;
            if (fill_arg)
                fill_data_q <= cmd_byte;
            if (is_test)
                test_q <= 1'b1;
            else if (is_nop || is_rst)
                test_q <= 1'b0;
            if (is_rst)
                contrast_q <= lcdcmd_pkg::CONTRAST_RST;
        end
    end

    // ==========================================
    // power save and sleep
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            disp_on_q <= 1'b0;
            entire_q  <= 1'b0;
            save_q    <= 1'b0;
            sleep_q   <= 1'b0;
        end
        else
        begin
            if (is_don)
                disp_on_q <= 1'b1;
            else if (is_doff)
                disp_on_q <= 1'b0;
            if (is_eon)
                entire_q <= 1'b1;
            else if (is_eoff)
                entire_q <= 1'b0;
            if (is_eon && !disp_on_q)
                save_q <= 1'b1;
            else if (is_eoff)
                save_q <= 1'b0;
            if (is_slon)
                sleep_q <= 1'b1;
            else if (is_sloff)
                sleep_q <= 1'b0;
        end
    end

    // ==========================================
    // line clock and frame polarity
    wire osc_run = timing_master && !sleep_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
            fcnt_q <= 6'h00;
            fpol_q <= 1'b0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (osc_run)
            begin
                div_q <= (div_q == 8'(lcdcmd_pkg::LINE_DIV - 1)) ? 8'h00 : div_q + 8'h01;
                tick_q <= (div_q == 8'(lcdcmd_pkg::LINE_DIV - 1));
            end
            if (tick_q && frs_q)
            begin
                if (fcnt_q >= period_lines(alt_q))
                begin
                    fcnt_q <= 6'h00;
                    fpol_q <= ~fpol_q;
                end
                else
                    fcnt_q <= fcnt_q + 6'h01;
            end
        end
    end

    // ==========================================
    // display memory, kept through power save
    always_ff @(posedge clk)
    begin
        if (fif.wr_en)
            ram[fif.wr_addr] <= fif.wr_data;
        else if (host_ram_wr)
            ram[host_ram_addr] <= host_ram_wdata;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q  <= 8'h00;
            status_q <= 8'h00;
        end
        else
        begin
            if (host_ram_rd)
                rdata_q <= ram[host_ram_addr];
            status_q <= 8'h00;
            status_q[lcdcmd_pkg::STATUS_BUSY]  <= busy || fif.busy;
            status_q[lcdcmd_pkg::STATUS_DISP]  <= !disp_on_q;
            status_q[lcdcmd_pkg::STATUS_RESET] <= reset_flag_q;
        end
    end

    // ==========================================
    // outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_enable     <= 1'b0;
            supply_enable  <= 1'b0;
            drive_enable   <= 1'b0;
            blanking_out_n <= 1'b1;
        end
        else
        begin
            osc_enable     <= osc_run;
            supply_enable  <= !sleep_q;
            drive_enable   <= !sleep_q;
            blanking_out_n <= !save_q;
        end
    end

    assign host_ram_rdata      = rdata_q;
    assign status_byte         = status_q;
    assign contrast_level      = contrast_q;
    assign dbl_start_line      = start_q;
    assign dbl_stop_line       = stop_q;
    assign dbl_size_on         = dbl_on_q;
    assign frame_invert_enable = frs_q;
    assign alt_period_sel      = alt_q;
    assign frame_polarity      = fpol_q;
    assign display_line_pulse  = tick_q;
    assign test_mode           = test_q;
    assign power_save          = save_q;
    assign sleep_mode          = sleep_q;
endmodule

// ---- lcdcmd_pkg.sv ----
// Purpose: constants for the lcd multibyte command interpreter
// Assumes: commands arrive one byte per strobe in the core clock domain
// Notes:   command codes, reset values and field positions
package lcdcmd_pkg;
    localparam logic [7:0] CMD_CONTRAST   = 8'h81;
    localparam logic [7:0] CMD_DBL_POS    = 8'hA9;
    localparam logic [7:0] CMD_DBL_NORMAL = 8'hA8;
    localparam logic [7:0] CMD_BURST      = 8'hE5;
    localparam logic [7:0] CMD_NOP        = 8'hE3;
    localparam logic [7:0] CMD_RESET      = 8'hE2;
    localparam logic [7:0] CMD_DISP_OFF   = 8'hAE;
    localparam logic [7:0] CMD_DISP_ON    = 8'hAF;
    localparam logic [7:0] CMD_ENTIRE_OFF = 8'hA4;
    localparam logic [7:0] CMD_ENTIRE_ON  = 8'hA5;
    localparam logic [7:0] CMD_SLEEP_OFF  = 8'hAD;
    localparam logic [7:0] CMD_SLEEP_ON   = 8'hAC;
    localparam logic [3:0] ALT_PREFIX     = 4'hD;
    localparam logic [3:0] TEST_PREFIX    = 4'hF;
    localparam int         ALT_FRS_BIT    = 3;
    localparam logic [5:0] CONTRAST_RST   = 6'h20;
    localparam logic [5:0] LINE_RST       = 6'h00;
    localparam logic [1:0] ALT_RST        = 2'h0;
    localparam int         FILL_LINES     = 17;
    localparam int         LINE_WIDTH     = 6;
    localparam int         LINE_DIV       = 8;
    localparam int         STATUS_BUSY    = 7;
    localparam int         STATUS_DISP    = 5;
    localparam int         STATUS_RESET   = 4;
    typedef enum logic [1:0]
    {
        LCDCMD_IDLE   = 2'b00,
        LCDCMD_VR     = 2'b01,
        LCDCMD_DSTART = 2'b11,
        LCDCMD_DSTOP  = 2'b10
    } lcdcmd_arg_t;
endpackage

// ---- lcdcmd_fill_if.sv ----
// Purpose: carrier between command decoder and burst fill engine
// Assumes: single clock
// Notes:   start pulse, data, busy and memory write port
`timescale 1ns/1ps
interface lcdcmd_fill_if #(parameter int AW = 10);
    logic          start;
    logic [7:0]    data;
    logic          busy;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0]    wr_data;
    modport ctrl (output start, output data, input busy, input wr_en, input wr_addr,
                  input wr_data);
    modport fill (input start, input data, output busy, output wr_en, output wr_addr,
                  output wr_data);
endinterface

// ---- lcdcmd_fill.sv ----
// Purpose: burst fill of display memory lasting at least a set number of line periods and until the last write
// Assumes: line_tick is a one-cycle enable per display line
// Notes:   writes one address per core clock until memory done, stays busy to end
`timescale 1ns/1ps
module lcdcmd_fill #(
    parameter int DEPTH = 1056,
    parameter int AW    = 11
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   line_tick,
    lcdcmd_fill_if.fill f
);
    if ((1 << AW) < DEPTH)
    begin
        $error("address width too small for depth");
    end

    logic [4:0]    lines_q;
    logic [AW-1:0] addr_q;
    logic          writing_q;
    logic [7:0]    data_q;
    logic          busy_q;
    wire           last_addr = (addr_q == AW'(DEPTH - 1));
    wire           last_line = (lines_q == 5'(lcdcmd_pkg::FILL_LINES));

    // ==========================================
    // fill sequencing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q    <= 1'b0;
            writing_q <= 1'b0;
            lines_q   <= 5'h00;
            addr_q    <= '0;
            data_q    <= 8'h00;
        end
        else if (f.start && !busy_q)
        begin
            busy_q    <= 1'b1;
            writing_q <= 1'b1;
            lines_q   <= 5'h00;
            addr_q    <= '0;
            data_q    <= f.data;
        end
        else if (busy_q)
        begin
            if (writing_q)
            begin
                addr_q <= addr_q + AW'(1);
                if (last_addr)
                    writing_q <= 1'b0;
            end
            if (line_tick && !last_line)
                lines_q <= lines_q + 5'h01;
            // busy holds until both the line count and the last write are done
            if (last_line && !writing_q)
                busy_q <= 1'b0;
        end
    end

    assign f.busy    = busy_q;
    assign f.wr_en   = writing_q;
    assign f.wr_addr = addr_q;
    assign f.wr_data = data_q;
endmodule

// ---- lcdcmd_core_properties.sv ----
// Purpose: port assertions for the lcd command interpreter
// Assumes: single clock, async active-low reset
// Notes:   helper counts argument bytes still owed
`timescale 1ns/1ps
module lcdcmd_core_properties (
    input logic       clk,
    input logic       rst_n,
    input logic       cmd_valid,
    input logic       command_data_select,
    input logic [7:0] cmd_byte,
    input logic [7:0] status_byte,
    input logic [5:0] contrast_level,
    input logic [5:0] dbl_stop_line,
    input logic       frame_invert_enable,
    input logic [1:0] alt_period_sel,
    input logic       test_mode,
    input logic       power_save,
    input logic       blanking_out_n,
    input logic       timing_master,
    input logic       osc_enable
);
    // ====================
    // argument tracking
    logic       take;
    logic       idle;
    logic       two;
    logic       one;
    logic [1:0] cnt_d;
    logic [1:0] cnt_q;
    logic [7:0] pend_q;
    assign take  = cmd_valid && !command_data_select;
    assign idle  = take && cnt_q == 2'h0 && !status_byte[7];
    assign two   = cmd_byte == 8'hA9;
    assign one   = cmd_byte == 8'h81 || cmd_byte == 8'hE5;
    assign cnt_d = idle ? {two, one} : (take && cnt_q != 2'h0) ? cnt_q - 2'h1 : cnt_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= 2'h0;
            pend_q <= 8'h00;
        end
        else
        begin
            cnt_q  <= cnt_d;
            pend_q <= idle ? cmd_byte : pend_q;
        end
    end
    // ====================
    // properties
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ctr;
        take && cnt_q == 2'h1 && pend_q == 8'h81 |=>
            contrast_level == $past(cmd_byte[5:0]) && test_mode == $past(test_mode);
    endproperty
    a_ctr: assert property (p_ctr) else $error("contrast byte not stored");
    property p_dstop;
        take && cnt_q == 2'h1 && pend_q == 8'hA9 |=> dbl_stop_line == $past(cmd_byte[5:0]);
    endproperty
    a_dstop: assert property (p_dstop) else $error("stop line not stored");
    property p_alt;
        idle && cmd_byte[7:4] == 4'hD |=> alt_period_sel == $past(cmd_byte[1:0])
            && frame_invert_enable == $past(cmd_byte[3]);
    endproperty
    a_alt: assert property (p_alt) else $error("alternating fields wrong");
    property p_test;
        idle && cmd_byte[7:4] == 4'hF |=> test_mode;
    endproperty
    a_test: assert property (p_test) else $error("test mode not entered");
    property p_nop;
        idle && cmd_byte == 8'hE3 |=> !test_mode && $stable(contrast_level);
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");
    property p_busy;
        take && cnt_q == 2'h1 && pend_q == 8'hE5 |-> ##[1:4] status_byte[7];
    endproperty
    a_busy: assert property (p_busy) else $error("fill not busy");
    property p_ps;
        power_save && !(idle && cmd_byte == 8'hA4) |=> power_save;
    endproperty
    a_ps: assert property (p_ps) else $error("power save left early");
    property p_blank;
        power_save [*2] |-> !blanking_out_n;
    endproperty
    a_blank: assert property (p_blank) else $error("blanking high in power save");
    property p_osc;
        !timing_master |=> !osc_enable;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator runs without master");
endmodule

bind lcdcmd_core lcdcmd_core_properties u_props (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .command_data_select(command_data_select), .cmd_byte(cmd_byte),
    .status_byte(status_byte), .contrast_level(contrast_level),
    .dbl_stop_line(dbl_stop_line), .frame_invert_enable(frame_invert_enable),
    .alt_period_sel(alt_period_sel), .test_mode(test_mode), .power_save(power_save),
    .blanking_out_n(blanking_out_n), .timing_master(timing_master), .osc_enable(osc_enable)
);

// ---- lcdcmd_host_model.sv ----
// Purpose: host processor writing command bytes
// Assumes: bytes launched after the falling clock edge
// Notes:   idle bus shows the inverse of the last byte
`timescale 1ns/1ps
module lcdcmd_host_model (
    input  logic       clk,
    input  logic [7:0] status_byte,
    output logic       cmd_valid,
    output logic       command_data_select,
    output logic [7:0] cmd_byte
);
    initial
    begin
        cmd_valid           = 1'b0;
        command_data_select = 1'b1;
        cmd_byte            = 8'h00;
    end
    // ====================
    // one strobed byte, optional slow start
    task automatic put(input logic [7:0] b, input int gap = 0);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        cmd_valid           = 1'b1;
        command_data_select = 1'b0;
        cmd_byte            = b;
        @(negedge clk);
        cmd_valid           = 1'b0;
        command_data_select = 1'b1;
        cmd_byte            = ~b;
        @(negedge clk);
    endtask
    // poll busy under a bound
    task automatic wait_ready(output logic ok);
        int n;
        n = 0;
        repeat (4) @(negedge clk);
        while (status_byte[7] !== 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        ok = n < 2000;
    endtask
endmodule

// ---- test_lcdcmd_core.sv ----
// Purpose: self-checking bench for lcdcmd_core
// Assumes: inputs change on the falling edge
// Notes:   memory depth 1056, line pulse every 8 clocks
`timescale 1ns/1ps
module test_lcdcmd_core;
    logic        clk, rst_n, timing_master, host_ram_wr, host_ram_rd, ok;
    logic        cmd_valid, command_data_select, dbl_size_on, frame_invert_enable;
    logic        frame_polarity, display_line_pulse, test_mode, power_save, sleep_mode;
    logic        osc_enable, supply_enable, drive_enable, blanking_out_n;
    logic [1:0]  alt_period_sel;
    logic [5:0]  contrast_level, dbl_start_line, dbl_stop_line;
    logic [7:0]  cmd_byte, host_ram_wdata, host_ram_rdata, status_byte;
    logic [10:0] host_ram_addr;
    int          failures, n_checks;
    lcdcmd_core dut (
        .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .command_data_select(command_data_select), .cmd_byte(cmd_byte),
        .timing_master(timing_master), .host_ram_wr(host_ram_wr),
        .host_ram_addr(host_ram_addr), .host_ram_wdata(host_ram_wdata),
        .host_ram_rd(host_ram_rd), .host_ram_rdata(host_ram_rdata),
        .status_byte(status_byte), .contrast_level(contrast_level),
        .dbl_start_line(dbl_start_line), .dbl_stop_line(dbl_stop_line),
        .dbl_size_on(dbl_size_on), .frame_invert_enable(frame_invert_enable),
        .alt_period_sel(alt_period_sel), .frame_polarity(frame_polarity),
        .display_line_pulse(display_line_pulse), .test_mode(test_mode),
        .power_save(power_save), .sleep_mode(sleep_mode), .osc_enable(osc_enable),
        .supply_enable(supply_enable), .drive_enable(drive_enable),
        .blanking_out_n(blanking_out_n)
    );
    lcdcmd_host_model host (
        .clk(clk), .status_byte(status_byte), .cmd_valid(cmd_valid),
        .command_data_select(command_data_select), .cmd_byte(cmd_byte)
    );
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ====================
    // compare and report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic flg(input logic got, input logic exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // write stores d, read compares with d
    task automatic ram(input logic wr, input logic [10:0] a, input logic [7:0] d);
        @(negedge clk);
        host_ram_wr    = wr;
        host_ram_rd    = !wr;
        host_ram_addr  = a;
        host_ram_wdata = d;
        @(negedge clk);
        host_ram_wr = 1'b0;
        host_ram_rd = 1'b0;
        if (!wr)
            chk(host_ram_rdata, d);
    endtask
    // ====================
    // scenarios
    task automatic t_ctr;
        host.put(8'h81);
        host.put(8'hF5, 3);
        chk({2'h0, contrast_level}, 8'h35);
        flg(test_mode, 1'b0);
        host.put(8'h81);
        host.put(8'h3F);
        chk({2'h0, contrast_level}, 8'h3F);
        host.put(8'h81);
        host.put(8'hC0);
        chk({2'h0, contrast_level}, 8'h00);
    endtask
    task automatic t_dbl;
        host.put(8'hA9);
        host.put(8'h08);
        host.put(8'hCF);
        chk({2'h0, dbl_start_line}, 8'h08);
        chk({2'h0, dbl_stop_line}, 8'h0F);
        flg(dbl_size_on, 1'b1);
        host.put(8'hA8);
        flg(dbl_size_on, 1'b0);
    endtask
    task automatic t_alt;
        int   k;
        int   n;
        logic p;
        for (int i = 0; i < 4; i++)
        begin
            host.put({4'hD, 2'h2, i[1:0]});
            chk({6'h0, alt_period_sel}, i[7:0]);
            flg(frame_invert_enable, 1'b1);
            k = 0;
            n = 0;
            for (int t = 0; t < 3; t++)
            begin
                p = frame_polarity;
                n = 0;
                while (frame_polarity === p && k < 4000)
                begin
                    @(negedge clk);
                    k++;
                    if (display_line_pulse === 1'b1)
                        n++;
                end
            end
            chk(n[7:0], 8'(16 * (i + 1)));
        end
    endtask
    task automatic t_test;
        host.put(8'hF0);
        flg(test_mode, 1'b1);
        host.put(8'hE3);
        flg(test_mode, 1'b0);
        chk({2'h0, contrast_level}, 8'h00);
        host.put(8'hF7);
        host.put(8'hE2);
        flg(test_mode, 1'b0);
        chk({2'h0, contrast_level}, 8'h20);
        host.put(8'h81);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        host.put(8'hF1);
        flg(test_mode, 1'b1);
        chk({2'h0, contrast_level}, 8'h20);
        host.put(8'hE3);
        flg(test_mode, 1'b0);
    endtask
    task automatic t_fill;
        ram(1'b1, 11'h005, 8'h11);
        host.put(8'hE5);
        host.put(8'hA5);
        repeat (2) @(negedge clk);
        flg(status_byte[7], 1'b1);
        host.put(8'h81);
        host.put(8'h3F);
        host.wait_ready(ok);
        flg(ok, 1'b1);
        chk({2'h0, contrast_level}, 8'h20);
        ram(1'b0, 11'h000, 8'hA5);
        ram(1'b0, 11'h005, 8'hA5);
        ram(1'b0, 11'h41F, 8'hA5);
    endtask
    task automatic t_power;
        host.put(8'hAE);
        chk(status_byte, 8'h20);
        host.put(8'hA5);
        flg(power_save, 1'b1);
        flg(blanking_out_n, 1'b0);
        ram(1'b1, 11'h007, 8'h3C);
        ram(1'b0, 11'h007, 8'h3C);
        host.put(8'hAF);
        flg(power_save, 1'b1);
        chk(status_byte, 8'h00);
        chk({2'h0, contrast_level}, 8'h20);
        host.put(8'hA4);
        flg(power_save, 1'b0);
        flg(blanking_out_n, 1'b1);
    endtask
    task automatic t_sleep;
        flg(osc_enable, 1'b1);
        host.put(8'hAC);
        flg(sleep_mode, 1'b1);
        flg(osc_enable, 1'b0);
        flg(supply_enable, 1'b0);
        flg(drive_enable, 1'b0);
        host.put(8'hAD);
        flg(osc_enable, 1'b1);
        timing_master = 1'b0;
        repeat (2) @(negedge clk);
        flg(osc_enable, 1'b0);
        flg(display_line_pulse, 1'b0);
        timing_master = 1'b1;
        repeat (2) @(negedge clk);
        flg(osc_enable, 1'b1);
    endtask
    initial
    begin
        failures       = 0;
        n_checks       = 0;
        rst_n          = 1'b0;
        timing_master  = 1'b1;
        host_ram_wr    = 1'b0;
        host_ram_rd    = 1'b0;
        host_ram_addr  = 11'h000;
        host_ram_wdata = 8'h00;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk({2'h0, contrast_level}, 8'h20);
        t_ctr;
        t_dbl;
        t_alt;
        t_test;
        t_fill;
        t_power;
        t_sleep;
        conclude;
    end
    initial
    begin
        #200000;
        failures++;
        conclude;
    end
endmodule
